// ===== design/scms_pkg.sv
`default_nettype none
package scms_pkg;
	// Pins from the host, all asynchronous to clk_sys.
	typedef struct packed {
		logic stepClk;
		logic rotationDirection;
		logic [2:0] stepResSel;
		logic angleInit;
		logic outputEnable;
		logic standbyN;
	} scms_pins_t;

	// Comparator and fault detector levels from the analog side.
	typedef struct packed {
		logic vbatBelowEnter;
		logic vbatAboveExit;
		logic railBelowEnter;
		logic railAboveExit;
		logic overCurrent;
		logic overTemp;
		logic loadOpen;
	} scms_sense_t;

	// Bridge polarity and current settings in percent of full scale.
	typedef struct packed {
		logic phaseAPos;
		logic phaseANeg;
		logic phaseBPos;
		logic phaseBNeg;
		logic [6:0] magA;
		logic [6:0] magB;
	} scms_drive_t;

	// Step resolution codes, first select bit most significant.
	localparam logic [2:0] RES_HOLD = 3'h0;
	localparam logic [2:0] RES_FULL = 3'h1;
	localparam logic [2:0] RES_HALF_A = 3'h2;
	localparam logic [2:0] RES_QUARTER = 3'h3;
	localparam logic [2:0] RES_HALF_B = 3'h4;
	localparam logic [2:0] RES_EIGHTH = 3'h5;
	localparam logic [2:0] RES_SIXTEENTH = 3'h6;
	localparam logic [2:0] RES_THIRTYSECOND = 3'h7;

	// One electrical cycle is 128 positions of 1/32 step; 45 degrees is 16.
	localparam int ANGLE_W = 7;
	localparam logic [6:0] ANGLE_INIT = 7'h10;
	localparam logic [6:0] QUARTER_SPAN = 7'h20;
	localparam logic [5:0] QUARTER_SPAN6 = 6'h20;
	localparam logic [6:0] MAG_FULL = 7'h64;
	localparam logic [6:0] MAG_ANOMALY_FLAG_N = 7'h47;
	localparam logic [6:0] MAG_ZERO = 7'h00;

	// Timing: the anomaly latch release time with enable low.
	localparam int CLK_PERIOD_NS = 10;
	localparam int ANOMALY_CLEAR_NS = 200000;
	localparam int ANOMALY_CLEAR_CYCLES = (ANOMALY_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWM_PERIOD_CYCLES = 2000;

	// Register map, byte addresses on the Avalon slave.
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_DRIVE = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam int CTRL_KILL_BIT = 0;

	// Angle increment for each resolution.
	function automatic logic [6:0] scms_step_size(input logic [2:0] res);
		case (res)
			RES_FULL: scms_step_size = 7'h20;
			RES_HALF_A: scms_step_size = 7'h10;
			RES_HALF_B: scms_step_size = 7'h10;
			RES_QUARTER: scms_step_size = 7'h08;
			RES_EIGHTH: scms_step_size = 7'h04;
			RES_SIXTEENTH: scms_step_size = 7'h02;
			RES_THIRTYSECOND: scms_step_size = 7'h01;
			default: scms_step_size = 7'h00;
		endcase
	endfunction : scms_step_size
endpackage : scms_pkg
`default_nettype wire

// ===== design/scms_sync.sv
`timescale 1ns/1ps
`default_nettype none
module scms_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Two flops; the first one feeds only the second.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;
endmodule : scms_sync
`default_nettype wire

// ===== design/scms_sine_rom.sv
`timescale 1ns/1ps
`default_nettype none
module scms_sine_rom (
	input wire logic clk_sys,
	input wire logic [5:0] idxA,
	input wire logic [5:0] idxB,
	output logic [6:0] magA_q,
	output logic [6:0] magB_q
);
	// Quarter sine in percent, 33 points from 0 to 90 degrees.
	localparam logic [6:0] SINE_TAB [0:32] = '{
		7'h00, 7'h05, 7'h0a, 7'h0f, 7'h14, 7'h18, 7'h1d, 7'h22,
		7'h26, 7'h2b, 7'h2f, 7'h33, 7'h38, 7'h3c, 7'h3f, 7'h43,
		7'h47, 7'h4a, 7'h4d, 7'h50, 7'h53, 7'h56, 7'h58, 7'h5a,
		7'h5c, 7'h5e, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64,
		7'h64
	};

	// Registered read keeps the table off the output paths.
	always_ff @(posedge clk_sys) begin
		magA_q <= SINE_TAB[idxA];
		magB_q <= SINE_TAB[idxB];
	end
endmodule : scms_sine_rom
`default_nettype wire

// ===== design/scms_sequencer.sv
// Notes on behaviour
// - Battery undervoltage, with hysteresis, disables motor outputs.
// - Rail undervoltage disables outputs, resets the step, drive and fault logic.
// - Logic keeps running after standby until rail fails.
// - Each rising step edge advances angle once, except in hold or angle initialise.
// - Enable gates drivers; counter keeps counting.
// - Enable low 0.2ms clears latched fault; persistent refaults.
// - Clockwise: A leads B; otherwise B leads.
// - Three select bits decode eight step resolutions.
// - Hold code gives 71 percent, monitor low.
// - Resolution change applies at next step edge.
// - Angle initialise holds 45 degrees, monitor low.
// - Initial currents 100 or 71 by mode.
// - Angle initialise takes effect on step edges.
// - Monitor pulls low at initial position and in hold.
// - Drive starts at next PWM period start.
// - Standby forces outputs off over enable.
// - Disabled outputs still let steps advance counter.
`timescale 1ns/1ps
`default_nettype none
module scms_sequencer #(
	parameter int ANOMALY_CLEAR_CYCLES = scms_pkg::ANOMALY_CLEAR_CYCLES,
	parameter int PWM_PERIOD_CYCLES = scms_pkg::PWM_PERIOD_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire scms_pkg::scms_pins_t ctrlPins,
	input wire scms_pkg::scms_sense_t senseFlags,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output scms_pkg::scms_drive_t motorOut,
	output logic motorOutOeN,
	output logic initialAngleMonitorOut,
	output logic initialAngleMonitorOeN,
	output logic anomalyFlagNOut,
	output logic anomalyFlagNOeN
);
	localparam int CLR_W = $clog2(ANOMALY_CLEAR_CYCLES + 1);
	localparam int PWM_W = $clog2(PWM_PERIOD_CYCLES);
	localparam logic [CLR_W-1:0] CLR_LAST = CLR_W'(ANOMALY_CLEAR_CYCLES);
	localparam logic [PWM_W-1:0] PWM_LAST = PWM_W'(PWM_PERIOD_CYCLES - 1);

	scms_pkg::scms_pins_t pins;
	scms_pkg::scms_sense_t sense;

	// Every pin and analog level is asynchronous, so all pass two flops.
	scms_sync #(
		.WIDTH($bits(scms_pkg::scms_pins_t))
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(ctrlPins),
		.dout(pins)
	);

	scms_sync #(
		.WIDTH($bits(scms_pkg::scms_sense_t))
	) u_sense_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(senseFlags),
		.dout(sense)
	);

	// Undervoltage states with hysteresis from the paired comparators.
	logic batUv_q;
	logic batUv_d;
	logic railUv_q;
	logic railUv_d;
	logic logicRst;

	assign batUv_d = sense.vbatBelowEnter ? 1'b1 : (sense.vbatAboveExit ? 1'b0 : batUv_q);
	assign railUv_d = sense.railBelowEnter ? 1'b1 : (sense.railAboveExit ? 1'b0 : railUv_q);

	// Both start in undervoltage so outputs stay off until the supplies prove good.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			batUv_q <= 1'b1;
			railUv_q <= 1'b1;
		end else begin
			batUv_q <= batUv_d;
			railUv_q <= railUv_d;
		end
	end

	assign logicRst = rst | railUv_q;

	// Step edge detection on the synchronised step clock.
	logic stepPrev_q;
	logic stepRise;

	always_ff @(posedge clk_sys) begin
		if (logicRst) begin
			stepPrev_q <= 1'b0;
		end else begin
			stepPrev_q <= pins.stepClk;
		end
	end

	assign stepRise = pins.stepClk & ~stepPrev_q;

	// Angle counter and resolution, both updated on step edges.
	logic [6:0] angle_q;
	logic [6:0] angle_d;
	logic [2:0] res_q;
	logic [6:0] stepSize;
	logic [6:0] stepMask;
	logic [6:0] stepSum;
	logic [6:0] stepAligned;
	logic [6:0] stepOffset;

	// new resolution used at the edge
	assign stepSize = scms_pkg::scms_step_size(pins.stepResSel);
	assign stepMask = ~(stepSize - 7'h01);
	assign stepSum = pins.rotationDirection ? (angle_q + stepSize) : (angle_q - stepSize);
	// Full steps sit on odd multiples of 45 degrees; finer modes on their own grid.
	assign stepOffset = (pins.stepResSel == scms_pkg::RES_FULL) ? scms_pkg::ANGLE_INIT : 7'h00;
	assign stepAligned = (stepSum & stepMask) | stepOffset;

	assign angle_d = pins.angleInit ? scms_pkg::ANGLE_INIT :
		((pins.stepResSel == scms_pkg::RES_HOLD) ? angle_q : stepAligned);

	always_ff @(posedge clk_sys) begin
		if (logicRst) begin
			angle_q <= scms_pkg::ANGLE_INIT;
			res_q <= scms_pkg::RES_HOLD;
		end else if (stepRise) begin
			angle_q <= angle_d;
			res_q <= pins.stepResSel;
		end
	end

	// Phase angles: B follows the angle as a sine, A is the sine 90 degrees ahead.
	logic [6:0] angleA;
	logic [4:0] offA;
	logic [4:0] offB;
	logic [5:0] romIdxA;
	logic [5:0] romIdxB;
	logic [6:0] romMagA;
	logic [6:0] romMagB;
	logic negA_q;
	logic negB_q;
	logic [2:0] resLag_q;

	assign angleA = angle_q + scms_pkg::QUARTER_SPAN;
	assign offA = angleA[4:0];
	assign offB = angle_q[4:0];
	assign romIdxA = angleA[5] ? (scms_pkg::QUARTER_SPAN6 - {1'b0, offA}) : {1'b0, offA};
	assign romIdxB = angle_q[5] ? (scms_pkg::QUARTER_SPAN6 - {1'b0, offB}) : {1'b0, offB};

	scms_sine_rom u_sine_rom (
		.clk_sys(clk_sys),
		.idxA(romIdxA),
		.idxB(romIdxB),
		.magA_q(romMagA),
		.magB_q(romMagB)
	);

	// Sign and mode are delayed one cycle to line up with the table read.
	always_ff @(posedge clk_sys) begin
		if (logicRst) begin
			negA_q <= 1'b0;
			negB_q <= 1'b0;
			resLag_q <= scms_pkg::RES_HOLD;
		end else begin
			negA_q <= angleA[6];
			negB_q <= angle_q[6];
			resLag_q <= res_q;
		end
	end

	// Current settings by resolution.
	logic fullLevels;
	logic holdMode;
	logic [6:0] magA_d;
	logic [6:0] magB_d;

	assign holdMode = (resLag_q == scms_pkg::RES_HOLD);
	// full and half a run flat
	assign fullLevels = (resLag_q == scms_pkg::RES_FULL) | (resLag_q == scms_pkg::RES_HALF_A);
	assign magA_d = holdMode ? scms_pkg::MAG_ANOMALY_FLAG_N :
		((fullLevels && romMagA != scms_pkg::MAG_ZERO) ? scms_pkg::MAG_FULL : romMagA);
	assign magB_d = holdMode ? scms_pkg::MAG_ANOMALY_FLAG_N :
		((fullLevels && romMagB != scms_pkg::MAG_ZERO) ? scms_pkg::MAG_FULL : romMagB);

	// PWM period timer; it runs free and so is unrelated to the step clock.
	logic [PWM_W-1:0] pwmCount_q;
	logic pwmStart;

	assign pwmStart = (pwmCount_q == PWM_LAST);

	always_ff @(posedge clk_sys) begin
		if (logicRst) begin
			pwmCount_q <= '0;
		end else if (pwmStart) begin
			pwmCount_q <= '0;
		end else begin
			pwmCount_q <= pwmCount_q + PWM_W'(1);
		end
	end

	// Drive arming. Disabling is immediate; enabling waits for a period start.
	logic ctrlKill_q;
	logic driveAllowed;
	logic armed_q;
	logic armed_d;

	assign driveAllowed = pins.outputEnable & pins.standbyN & ~batUv_q & ~ctrlKill_q;
	assign armed_d = driveAllowed & (armed_q | pwmStart);

	always_ff @(posedge clk_sys) begin
		if (logicRst) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
		end
	end

	// Registered drive outputs; current zero leaves both legs low.
	scms_pkg::scms_drive_t drive_q;

	always_ff @(posedge clk_sys) begin
		if (logicRst) begin
			drive_q <= '0;
		end else begin
			drive_q.magA <= magA_d;
			drive_q.magB <= magB_d;
			drive_q.phaseAPos <= (magA_d != scms_pkg::MAG_ZERO) & (holdMode | ~negA_q);
			drive_q.phaseANeg <= (magA_d != scms_pkg::MAG_ZERO) & ~holdMode & negA_q;
			drive_q.phaseBPos <= (magB_d != scms_pkg::MAG_ZERO) & (holdMode | ~negB_q);
			drive_q.phaseBNeg <= (magB_d != scms_pkg::MAG_ZERO) & ~holdMode & negB_q;
		end
	end

	assign motorOut = drive_q;
	assign motorOutOeN = ~armed_q;

	// Angle monitor, low at the initial position, in hold and while initialising.
	logic monLow;

	assign monLow = (angle_q == scms_pkg::ANGLE_INIT) | (res_q == scms_pkg::RES_HOLD);
	assign initialAngleMonitorOut = 1'b0;
	assign initialAngleMonitorOeN = ~monLow;

	// Anomaly latch with release after enable has stayed low long enough.
	logic [CLR_W-1:0] enLowCount_q;
	logic enLowDone;
	logic faultLatch_q;
	logic faultLatch_d;
	logic latchFault;

	assign enLowDone = (enLowCount_q == CLR_LAST);
	assign latchFault = sense.overCurrent | sense.overTemp;
	assign faultLatch_d = latchFault | (faultLatch_q & ~enLowDone);

	always_ff @(posedge clk_sys) begin
		if (logicRst || pins.outputEnable) begin
			enLowCount_q <= '0;
		end else if (!enLowDone) begin
			enLowCount_q <= enLowCount_q + CLR_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (logicRst) begin
			faultLatch_q <= 1'b0;
		end else begin
			faultLatch_q <= faultLatch_d;
		end
	end

	// Load open is reported live; it is not latched.
	assign anomalyFlagNOut = 1'b0;
	assign anomalyFlagNOeN = ~(faultLatch_q | sense.loadOpen);

	// Avalon slave: one wait cycle, then the answer. Kept on rst only so that
	// software still sees the undervoltage state while the logic is held.
	logic ack_q;
	logic req;
	logic accept;
	logic hitStatus;
	logic hitDrive;
	logic hitCtrl;
	logic [31:0] statusWord;
	logic [31:0] driveWord;
	logic [31:0] ctrlWord;
	logic [31:0] readMux;
	logic [31:0] readdata_q;

	assign req = avs_read | avs_write;
	assign accept = req & ack_q;
	assign avs_waitrequest = req & ~ack_q;
	assign hitStatus = (avs_address == scms_pkg::REG_STATUS);
	assign hitDrive = (avs_address == scms_pkg::REG_DRIVE);
	assign hitCtrl = (avs_address == scms_pkg::REG_CTRL);

	assign statusWord = {16'h0000, faultLatch_q, sense.loadOpen, batUv_q, railUv_q,
		armed_q, res_q, 1'b0, angle_q};
	assign driveWord = {12'h000, drive_q.phaseAPos, drive_q.phaseANeg, drive_q.phaseBPos,
		drive_q.phaseBNeg, 1'b0, drive_q.magA, 1'b0, drive_q.magB};
	assign ctrlWord = {31'h00000000, ctrlKill_q};
	// Unmapped addresses read zero and ignore writes.
	assign readMux = hitStatus ? statusWord : (hitDrive ? driveWord : (hitCtrl ? ctrlWord : 32'h0));

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0;
		end else begin
			ack_q <= req & ~ack_q;
			readdata_q <= (avs_read && !ack_q) ? readMux : readdata_q;
		end
	end

	// Software output kill, a last-resort stop beside the enable pin.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrlKill_q <= 1'b0;
		end else if (accept && avs_write && hitCtrl) begin
			ctrlKill_q <= avs_writedata[scms_pkg::CTRL_KILL_BIT];
		end
	end

	assign avs_readdata = readdata_q;
endmodule : scms_sequencer
`default_nettype wire

// ===== sim/scms_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module scms_sequencer_sva #(
	parameter int ANOMALY_CLEAR_CYCLES = scms_pkg::ANOMALY_CLEAR_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire scms_pkg::scms_pins_t ctrlPins,
	input wire scms_pkg::scms_sense_t senseFlags,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire scms_pkg::scms_drive_t motorOut,
	input wire logic motorOutOeN,
	input wire logic initialAngleMonitorOeN,
	input wire logic anomalyFlagNOeN
);
	logic railOk;
	logic quiet;
	logic [31:0] quietCnt_q;
	logic [31:0] quietCnt_d;
	// Fault-free cycles with enable low; the margin covers the input synchronisers.
	assign railOk = senseFlags.railAboveExit && !senseFlags.railBelowEnter;
	assign quiet = !ctrlPins.outputEnable && railOk && !senseFlags.overCurrent
		&& !senseFlags.overTemp && !senseFlags.loadOpen;
	assign quietCnt_d = quiet ? quietCnt_q + 32'h1 : 32'h0;
	always_ff @(posedge clk_sys) begin
		quietCnt_q <= rst ? 32'h0 : quietCnt_d;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Output gating, fault latch, angle mapping and bus handshake.
	a_standby_off: assert property ((!ctrlPins.standbyN)[*6] |-> motorOutOeN)
		else $error("outputs driven in standby");
	a_enable_gate: assert property ((!ctrlPins.outputEnable)[*6] |-> motorOutOeN)
		else $error("outputs driven with enable low");
	a_bat_off: assert property (senseFlags.vbatBelowEnter[*6] |-> motorOutOeN)
		else $error("outputs driven in battery undervoltage");
	a_rail_reset: assert property (senseFlags.railBelowEnter[*8] |->
		motorOutOeN && !initialAngleMonitorOeN)
		else $error("rail undervoltage did not reset");
	a_init_level: assert property ((!initialAngleMonitorOeN && !motorOutOeN)[*4] |->
		motorOut.magA == motorOut.magB && (motorOut.magA == scms_pkg::MAG_FULL
		|| motorOut.magA == scms_pkg::MAG_ANOMALY_FLAG_N))
		else $error("initial position currents wrong");
	a_zero_legs: assert property (motorOut.magA == scms_pkg::MAG_ZERO |->
		!motorOut.phaseAPos && !motorOut.phaseANeg)
		else $error("leg driven at zero current");
	a_mag_range: assert property (motorOut.magB <= scms_pkg::MAG_FULL
		&& !(motorOut.phaseBPos && motorOut.phaseBNeg))
		else $error("phase b setting out of range");
	a_step_only: assert property (($stable(ctrlPins.stepClk) && !senseFlags.railBelowEnter)[*8]
		|-> $stable(initialAngleMonitorOeN))
		else $error("angle moved without a step edge");
	a_fault_set: assert property ((senseFlags.overCurrent && railOk)[*7] |->
		!anomalyFlagNOeN)
		else $error("fault flag not raised");
	a_fault_clear: assert property (quietCnt_q == ANOMALY_CLEAR_CYCLES + 6 |->
		anomalyFlagNOeN)
		else $error("fault flag not released");
	a_bus_wait: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus wait state wrong");
	c_arm_drop: cover property (!motorOutOeN ##1 motorOutOeN);
	c_fault_free: cover property ($rose(anomalyFlagNOeN));
	c_leave_init: cover property ($rose(initialAngleMonitorOeN));
endmodule : scms_sequencer_sva
bind scms_sequencer scms_sequencer_sva #(.ANOMALY_CLEAR_CYCLES(ANOMALY_CLEAR_CYCLES)) u_sva (
	.clk_sys(clk_sys), .rst(rst), .ctrlPins(ctrlPins), .senseFlags(senseFlags),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.motorOut(motorOut), .motorOutOeN(motorOutOeN),
	.initialAngleMonitorOeN(initialAngleMonitorOeN), .anomalyFlagNOeN(anomalyFlagNOeN));
`default_nettype wire

// ===== sim/scms_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scms_host_model #(
	parameter int SETTLE_CYCLES = 50000
) (
	input wire logic clk_sys,
	output var scms_pkg::scms_pins_t pins
);
	// Every pin starts low: standby asserted, outputs disabled.
	initial begin
		pins = '0;
	end
	// One pulse per step, high and low about half the link period each.
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pins.stepClk <= 1'b1;
			repeat (6) @(posedge clk_sys);
			pins.stepClk <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
	endtask : step
	task automatic setc(input logic dir, input logic [2:0] res, input logic init);
		@(posedge clk_sys);
		pins.rotationDirection <= dir;
		pins.stepResSel <= res;
		pins.angleInit <= init;
	endtask : setc
	// Raw enable and standby levels, so a test can also break the ordering.
	task automatic setp(input logic en, input logic sb);
		@(posedge clk_sys);
		pins.outputEnable <= en;
		pins.standbyN <= sb;
	endtask : setp
	task automatic power_up();
		setp(1'b0, 1'b1);
		repeat (SETTLE_CYCLES) @(posedge clk_sys);
	endtask : power_up
	task automatic power_down();
		setp(1'b0, 1'b1);
		repeat (4) @(posedge clk_sys);
		setp(1'b0, 1'b0);
	endtask : power_down
endmodule : scms_host_model
`default_nettype wire

// ===== sim/tb_step_clock_motor_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_step_clock_motor_sequencer;
	localparam int ACLR = 20;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	scms_pkg::scms_pins_t pins;
	scms_pkg::scms_sense_t sense;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	scms_pkg::scms_drive_t motorOut;
	logic motorOutOeN;
	logic monOeN;
	logic flagOeN;
	logic monOut;
	logic flagOut;
	logic [31:0] rd;
	logic [6:0] m;
	int n_mismatch = 0;
	int cmp_count = 0;
	int stepSz [8] = '{0, 32, 16, 8, 16, 4, 2, 1};
	always #5 clk_sys = ~clk_sys;
	scms_sequencer #(.ANOMALY_CLEAR_CYCLES(ACLR), .PWM_PERIOD_CYCLES(8)) dut (
		.clk_sys(clk_sys), .rst(rst), .ctrlPins(pins), .senseFlags(sense),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .motorOut(motorOut), .motorOutOeN(motorOutOeN),
		.initialAngleMonitorOut(monOut), .initialAngleMonitorOeN(monOeN),
		.anomalyFlagNOut(flagOut), .anomalyFlagNOeN(flagOeN));
	scms_host_model #(.SETTLE_CYCLES(50)) host (.clk_sys(clk_sys), .pins(pins));
	// The request stands until a rising edge sees waitrequest low; data is taken there.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rdchk(input string w, input logic [3:0] a, input logic [31:0] mask,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0, rd);
		check(w, rd & mask, exp);
	endtask : rdchk
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	// A hang counts as a mismatch.
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		final_report();
	end
	initial begin
		sense = '0;
		sense.railAboveExit = 1'b1;
		sense.vbatAboveExit = 1'b1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		host.power_up();
		rdchk("angle", scms_pkg::REG_STATUS, 32'h7f, 32'h10);
		@(negedge clk_sys);
		check("monitor", monOeN, 32'h0);
		// Every resolution code: currents at 45 degrees, then one clockwise step.
		for (int i = 0; i < 8; i++) begin
			m = (i == 1 || i == 2) ? scms_pkg::MAG_FULL : scms_pkg::MAG_ANOMALY_FLAG_N;
			host.setc(1'b1, i[2:0], 1'b1);
			host.step(1);
			rdchk("init mag", scms_pkg::REG_DRIVE, 32'h7f7f, {17'h0, m, 1'b0, m});
			host.setc(1'b1, i[2:0], 1'b0);
			host.step(1);
			rdchk("res step", scms_pkg::REG_STATUS, 32'h77f,
				{21'h0, i[2:0], 1'b0, 7'(16 + stepSz[i])});
		end
		host.setc(1'b0, 3'h7, 1'b0);
		host.step(2);
		rdchk("ccw angle", scms_pkg::REG_STATUS, 32'h7f, 32'hf);
		@(negedge clk_sys);
		check("monitor off", monOeN, 32'h1);
		bus(1'b0, scms_pkg::REG_DRIVE, 32'h0, rd);
		check("phase order", {31'h0, rd[14:8] > rd[6:0]}, 32'h1);
		// Pin changes without a step edge must wait for the next edge.
		host.setc(1'b1, 3'h1, 1'b1);
		repeat (8) @(posedge clk_sys);
		rdchk("no edge", scms_pkg::REG_STATUS, 32'h77f, 32'h70f);
		host.step(1);
		rdchk("init edge", scms_pkg::REG_STATUS, 32'h77f, 32'h110);
		host.setc(1'b1, 3'h1, 1'b0);
		host.step(3);
		rdchk("full steps", scms_pkg::REG_STATUS, 32'h7f, 32'h70);
		host.step(1);
		rdchk("wrap", scms_pkg::REG_STATUS, 32'h7f, 32'h10);
		@(negedge clk_sys);
		check("monitor on", monOeN, 32'h0);
		// Arming, battery hysteresis, kill bit and standby priority.
		host.setp(1'b1, 1'b1);
		repeat (16) @(negedge clk_sys);
		check("armed", motorOutOeN, 32'h0);
		@(posedge clk_sys);
		sense.vbatAboveExit <= 1'b0;
		sense.vbatBelowEnter <= 1'b1;
		repeat (6) @(negedge clk_sys);
		check("bat uv", motorOutOeN, 32'h1);
		@(posedge clk_sys);
		sense.vbatBelowEnter <= 1'b0;
		repeat (20) @(negedge clk_sys);
		check("bat hyst", motorOutOeN, 32'h1);
		@(posedge clk_sys);
		sense.vbatAboveExit <= 1'b1;
		repeat (20) @(negedge clk_sys);
		check("bat ok", motorOutOeN, 32'h0);
		bus(1'b1, scms_pkg::REG_CTRL, 32'h1, rd);
		rdchk("kill", scms_pkg::REG_CTRL, 32'h1, 32'h1);
		@(negedge clk_sys);
		check("kill off", motorOutOeN, 32'h1);
		bus(1'b1, scms_pkg::REG_CTRL, 32'h0, rd);
		rdchk("unmapped", 4'hc, 32'hffffffff, 32'h0);
		host.setp(1'b1, 1'b0);
		repeat (6) @(negedge clk_sys);
		check("standby", motorOutOeN, 32'h1);
		// Fault latch holds, clears after a long disable, and refaults if it persists.
		@(posedge clk_sys);
		sense.overCurrent <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sense.overCurrent <= 1'b0;
		repeat (10) @(negedge clk_sys);
		check("latched", flagOeN, 32'h0);
		host.setp(1'b0, 1'b1);
		repeat (ACLR + 12) @(negedge clk_sys);
		check("released", flagOeN, 32'h1);
		@(posedge clk_sys);
		sense.overTemp <= 1'b1;
		repeat (ACLR + 12) @(negedge clk_sys);
		check("persists", flagOeN, 32'h0);
		@(posedge clk_sys);
		sense.overTemp <= 1'b0;
		// Rail undervoltage sends the angle home.
		host.setc(1'b1, 3'h7, 1'b0);
		host.step(1);
		@(posedge clk_sys);
		sense.railAboveExit <= 1'b0;
		sense.railBelowEnter <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rdchk("rail uv", scms_pkg::REG_STATUS, 32'h107f, 32'h1010);
		sense.railBelowEnter <= 1'b0;
		sense.railAboveExit <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rdchk("rail ok", scms_pkg::REG_STATUS, 32'h1000, 32'h0);
		// Load open is reported live on the open-drain flag, never latched.
		@(posedge clk_sys);
		sense.loadOpen <= 1'b1;
		repeat (4) @(negedge clk_sys);
		check("load open", flagOeN, 32'h0);
		check("flag level", flagOut, 32'h0);
		check("monitor level", monOut, 32'h0);
		@(posedge clk_sys);
		sense.loadOpen <= 1'b0;
		repeat (4) @(negedge clk_sys);
		check("load gone", flagOeN, 32'h1);
		host.power_down();
		final_report();
	end
endmodule : tb_step_clock_motor_sequencer
`default_nettype wire
